/* src/tpds_pkg.sv */
/*
 * Constants shared by the tuner power-up and offset-correction sequencer:
 * register offsets, field positions, reset values, timing and states.
 * Assumes a single 50 MHz core clock.
 */
package tpds_pkg;

    // Timing
    localparam int CLK_FREQ_MHZ       = 50;
    localparam int SEQ_TOTAL_US       = 2000;
    localparam int CAL_TIME_US        = 500;
    localparam int CAL_CYCLES         = CAL_TIME_US * CLK_FREQ_MHZ;
    localparam int PLL_SETTLE_CYCLES  = (SEQ_TOTAL_US - CAL_TIME_US) * CLK_FREQ_MHZ;

    // Serial bus device address, arbitrary value
    localparam logic [6:0] DEV_ADDR   = 7'h60;

    // Register offsets
    localparam logic [7:0] ADDR_TRK_FILTER = 8'h01;
    localparam logic [7:0] ADDR_SHUTDOWN   = 8'h09;
    localparam logic [7:0] ADDR_BB_CTRL    = 8'h0A;
    localparam logic [7:0] ADDR_VCO_CTRL   = 8'h0B;
    localparam logic [7:0] ADDR_DC_CTRL    = 8'h0C;
    localparam logic [7:0] ADDR_STATUS     = 8'h0D;

    // Field positions
    localparam int BALUN_LSB      = 4;
    localparam int LPF_BW_LSB     = 4;
    localparam int SD_PLL_BIT     = 0;
    localparam int SD_RXPATH_BIT  = 1;
    localparam int SD_BB_BIT      = 2;
    localparam int SD_REFBUF_BIT  = 7;
    localparam int OSC_SEL_LSB    = 6;
    localparam int SPEED_LSB      = 0;
    localparam int THRESH_LSB     = 2;
    localparam int MODE_LSB       = 4;
    localparam int ST_BUSY_BIT    = 0;
    localparam int ST_CALDONE_BIT = 1;
    localparam int ST_PIN_BIT     = 2;

    // Reset values
    localparam logic [7:0] RST_TRK_FILTER = 8'h00;
    localparam logic [7:0] RST_SHUTDOWN   = 8'h00;
    localparam logic [7:0] RST_BB_CTRL    = 8'h00;
    localparam logic [7:0] RST_VCO_CTRL   = 8'h40;
    localparam logic [7:0] RST_DC_CTRL    = 8'h1F;

    // Offset loop codes
    localparam logic [1:0] SPEED_HOLD = 2'h0;
    localparam logic [1:0] SPEED_FAST = 2'h3;
    localparam logic [1:0] MODE_OFF   = 2'h0;

    typedef enum logic [2:0] {
        SEQ_DOWN,
        SEQ_PLL,
        SEQ_CAL,
        SEQ_RUN
    } tpds_seq_e;

    typedef enum logic [3:0] {
        SB_IDLE,
        SB_ADDR,
        SB_ACK_ADDR,
        SB_REG,
        SB_ACK_REG,
        SB_WDATA,
        SB_ACK_W,
        SB_RDATA,
        SB_ACK_R
    } tpds_sbus_e;

endpackage : tpds_pkg

/* src/tpds_reg_if.sv */
/*
 * Register access carrier between the serial bus slave and the core.
 * Assumes both ends share the core clock.
 */
`timescale 1ns/100ps
interface tpds_reg_if;
    logic       wr_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;

    modport bus_side  (output wr_en, output addr, output wdata, input rdata);
    modport core_side (input wr_en, input addr, input wdata, output rdata);
endinterface : tpds_reg_if

/* src/tpds_serial_slave.sv */
/*
 * Two-wire serial bus slave: device address, register pointer, then
 * auto-incrementing data bytes for writes and reads.
 * Assumes clock and data pins already synchronous to the core clock.
 */
`timescale 1ns/100ps
module tpds_serial_slave
    import tpds_pkg::*;
(
    input  wire logic       i_core_clk,   // Core clock
    input  wire logic       i_rst,        // Async reset, high
    input  wire logic       i_scl,        // Serial clock
    input  wire logic       i_sda,        // Serial data in
    output logic            o_sda_out,    // Serial data out level
    output logic            o_sda_oe,     // Serial data drive enable
    tpds_reg_if.bus_side    reg_bus       // Register access
);
    tpds_sbus_e state;
    logic       scl_q;
    logic       sda_q;
    logic [7:0] shreg;
    logic [3:0] cnt;
    logic [7:0] ptr;
    logic       rw;
    logic       start_c;
    logic       stop_c;
    logic       scl_rise;
    logic       scl_fall;

    assign start_c  = scl_q & i_scl & sda_q & ~i_sda;
    assign stop_c   = scl_q & i_scl & ~sda_q & i_sda;
    assign scl_rise = ~scl_q & i_scl;
    assign scl_fall = scl_q & ~i_scl;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= i_scl;
            sda_q <= i_sda;
        end
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state         <= SB_IDLE;
            shreg         <= 8'h00;
            cnt           <= 4'h0;
            ptr           <= 8'h00;
            rw            <= 1'b0;
            reg_bus.wr_en <= 1'b0;
            reg_bus.wdata <= 8'h00;
        end else begin
            reg_bus.wr_en <= 1'b0;
            if (start_c) begin
                state <= SB_ADDR;
                cnt   <= 4'h0;
            end else if (stop_c) begin
                state <= SB_IDLE;
            end else if (scl_rise) begin
                unique case (state)
                    SB_ADDR, SB_REG, SB_WDATA: begin
                        shreg <= {shreg[6:0], i_sda};
                        cnt   <= cnt + 4'h1;
                    end
                    SB_ACK_R: begin
                        if (i_sda) begin
                            state <= SB_IDLE;
                        end
                    end
                    default: ;
                endcase
            end else if (scl_fall) begin
                unique case (state)
                    SB_ADDR: begin
                        if (cnt == 4'h8) begin
                            cnt   <= 4'h0;
                            rw    <= shreg[0];
                            state <= (shreg[7:1] == DEV_ADDR) ? SB_ACK_ADDR : SB_IDLE;
                        end
                    end
                    SB_ACK_ADDR: begin
                        if (rw) begin
                            shreg <= reg_bus.rdata;
                            state <= SB_RDATA;
                        end else begin
                            state <= SB_REG;
                        end
                    end
                    SB_REG: begin
                        if (cnt == 4'h8) begin
                            cnt   <= 4'h0;
                            ptr   <= shreg;
                            state <= SB_ACK_REG;
                        end
                    end
                    SB_ACK_REG: state <= SB_WDATA;
                    SB_WDATA: begin
                        if (cnt == 4'h8) begin
                            cnt           <= 4'h0;
                            reg_bus.wr_en <= 1'b1;
                            reg_bus.wdata <= shreg;
                            state         <= SB_ACK_W;
                        end
                    end
                    SB_ACK_W: begin
                        ptr   <= ptr + 8'h01;
                        state <= SB_WDATA;
                    end
                    SB_RDATA: begin
                        shreg <= {shreg[6:0], 1'b0};
                        cnt   <= cnt + 4'h1;
                        if (cnt == 4'h7) begin
                            cnt   <= 4'h0;
                            ptr   <= ptr + 8'h01;
                            state <= SB_ACK_R;
                        end
                    end
                    // Next read byte is fetched when the master acknowledges
                    SB_ACK_R: begin
                        shreg <= reg_bus.rdata;
                        state <= SB_RDATA;
                    end
                    default: ;
                endcase
            end
        end
    end

    assign reg_bus.addr = ptr;
    assign o_sda_out    = 1'b0;
    assign o_sda_oe     = (state == SB_ACK_ADDR) | (state == SB_ACK_REG) | (state == SB_ACK_W)
                        | ((state == SB_RDATA) & ~shreg[7]);

endmodule : tpds_serial_slave

/* src/tpds_sequencer.sv */
/*
 * Tuner power-up sequencer with offset-correction control and the
 * register file it serves, reached over the two-wire serial bus.
 * Assumes all pins synchronous to the 50 MHz core clock; the block
 * enables it drives are the analog blocks' power and loop controls.
 */
`timescale 1ns/100ps
module tpds_sequencer
    import tpds_pkg::*;
#(
    parameter int PLL_SETTLE = tpds_pkg::PLL_SETTLE_CYCLES,  // PLL settling step, cycles
    parameter int CAL_LEN    = tpds_pkg::CAL_CYCLES          // Offset calibration step, cycles
) (
    input  wire logic       i_core_clk,           // Core clock, 50 MHz
    input  wire logic       i_rst,                // Async reset, high
    input  wire logic       i_hw_powerdown_n,     // Hardware power-down, low
    input  wire logic       i_autocal_select_pin, // Low selects sequenced start-up
    input  wire logic       i_scl,                // Serial clock
    input  wire logic       i_sda,                // Serial data in
    output logic            o_sda_out,            // Serial data out level
    output logic            o_sda_oe,             // Serial data drive enable
    output logic            o_pll_en,             // Oscillator and PLL power
    output logic            o_rx_path_en,         // RF signal path power
    output logic            o_baseband_en,        // Baseband power
    output logic            o_ref_clock_out_en,   // Reference buffer enable
    output logic            o_agc_override,       // Override both gain controls
    output logic            o_offset_loop_en,     // Offset correction running
    output logic [1:0]      o_offset_speed,       // Applied correction rate
    output logic [1:0]      o_offset_threshold,   // Applied threshold
    output logic [1:0]      o_osc_core_select,    // Oscillator core select
    output logic [3:0]      o_lpf_bandwidth,      // Baseband filter setting
    output logic [3:0]      o_balun_tune,         // Balun tuning
    output logic            o_seq_busy            // Sequence in progress
);
    import tpds_pkg::*;

    localparam int CNT_W = $clog2(PLL_SETTLE + CAL_LEN + 1);

    tpds_reg_if reg_bus ();

    tpds_seq_e         state;
    logic [CNT_W-1:0]  cnt;
    logic              pin_q;
    logic              pin_rise;
    logic              cal_done;
    logic [7:0]        trk_filter;
    logic [7:0]        shutdown;
    logic [7:0]        bb_ctrl;
    logic [7:0]        vco_ctrl;
    logic [7:0]        dc_ctrl;
    logic [1:0]        speed;
    logic [1:0]        mode;
    logic              next_pll_en;
    logic              next_rx_path_en;
    logic              next_baseband_en;
    logic              next_agc_override;
    logic              next_loop_en;
    logic [1:0]        next_speed;

    tpds_serial_slave u_serial (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .i_scl      (i_scl),
        .i_sda      (i_sda),
        .o_sda_out  (o_sda_out),
        .o_sda_oe   (o_sda_oe),
        .reg_bus    (reg_bus.bus_side)
    );

    // Registers reset only on i_rst, never on the power-down pin
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            trk_filter <= RST_TRK_FILTER;
            shutdown   <= RST_SHUTDOWN;
            bb_ctrl    <= RST_BB_CTRL;
            vco_ctrl   <= RST_VCO_CTRL;
            dc_ctrl    <= RST_DC_CTRL;
        end else if (reg_bus.wr_en) begin
            unique case (reg_bus.addr)
                ADDR_TRK_FILTER: trk_filter <= reg_bus.wdata;
                ADDR_SHUTDOWN:   shutdown   <= reg_bus.wdata;
                ADDR_BB_CTRL:    bb_ctrl    <= reg_bus.wdata;
                ADDR_VCO_CTRL:   vco_ctrl   <= reg_bus.wdata;
                ADDR_DC_CTRL:    dc_ctrl    <= reg_bus.wdata;
                default: ;
            endcase
        end
    end

    always_comb begin
        unique case (reg_bus.addr)
            ADDR_TRK_FILTER: reg_bus.rdata = trk_filter;
            ADDR_SHUTDOWN:   reg_bus.rdata = shutdown;
            ADDR_BB_CTRL:    reg_bus.rdata = bb_ctrl;
            ADDR_VCO_CTRL:   reg_bus.rdata = vco_ctrl;
            ADDR_DC_CTRL:    reg_bus.rdata = dc_ctrl;
            ADDR_STATUS: begin
                reg_bus.rdata                 = 8'h00;
                reg_bus.rdata[ST_BUSY_BIT]    = o_seq_busy;
                reg_bus.rdata[ST_CALDONE_BIT] = cal_done;
                reg_bus.rdata[ST_PIN_BIT]     = pin_q;
            end
            default:         reg_bus.rdata = 8'h00;
        endcase
    end

    assign speed    = dc_ctrl[SPEED_LSB +: 2];
    assign mode     = dc_ctrl[MODE_LSB +: 2];
    assign pin_rise = i_hw_powerdown_n & ~pin_q;

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= i_hw_powerdown_n;
        end
    end

    // Power-up sequencer, timed in core clock cycles
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= SEQ_DOWN;
            cnt   <= '0;
        end else if (!i_hw_powerdown_n) begin
            state <= SEQ_DOWN;
            cnt   <= '0;
        end else begin
            unique case (state)
                SEQ_DOWN: begin
                    if (pin_rise) begin
                        if (!i_autocal_select_pin) begin
                            state <= SEQ_PLL;
                            cnt   <= CNT_W'(PLL_SETTLE - 1);
                        end else begin
                            state <= SEQ_RUN;
                        end
                    end
                end
                SEQ_PLL: begin
                    if (cnt == '0) begin
                        state <= SEQ_CAL;
                        cnt   <= CNT_W'(CAL_LEN - 1);
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                SEQ_CAL: begin
                    if (cnt == '0) begin
                        state <= SEQ_RUN;
                    end else begin
                        cnt <= cnt - 1'b1;
                    end
                end
                SEQ_RUN: ;
            endcase
        end
    end

    // Calibration completed since the last power-down exit
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            cal_done <= 1'b0;
        end else if (!i_hw_powerdown_n) begin
            cal_done <= 1'b0;
        end else if (state == SEQ_CAL && cnt == '0) begin
            cal_done <= 1'b1;
        end
    end

    always_comb begin
        next_pll_en       = 1'b0;
        next_rx_path_en   = 1'b0;
        next_baseband_en  = 1'b0;
        next_agc_override = 1'b0;
        next_loop_en      = 1'b0;
        next_speed        = SPEED_HOLD;
        unique case (state)
            SEQ_DOWN: ;
            SEQ_PLL: begin
                next_pll_en = 1'b1;
            end
            SEQ_CAL: begin
                next_pll_en       = 1'b1;
                next_rx_path_en   = 1'b1;
                next_baseband_en  = 1'b1;
                next_agc_override = 1'b1;
                next_loop_en      = 1'b1;
                next_speed        = SPEED_FAST;
            end
            SEQ_RUN: begin
                next_pll_en      = ~shutdown[SD_PLL_BIT];
                next_rx_path_en  = ~shutdown[SD_RXPATH_BIT];
                next_baseband_en = ~shutdown[SD_BB_BIT];
                next_speed       = speed;
                next_loop_en     = (speed != SPEED_HOLD) & (mode != MODE_OFF);
            end
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pll_en           <= 1'b0;
            o_rx_path_en       <= 1'b0;
            o_baseband_en      <= 1'b0;
            o_agc_override     <= 1'b0;
            o_offset_loop_en   <= 1'b0;
            o_offset_speed     <= SPEED_HOLD;
            o_offset_threshold <= 2'h0;
            o_ref_clock_out_en <= 1'b0;
            o_osc_core_select  <= 2'h0;
            o_lpf_bandwidth    <= 4'h0;
            o_balun_tune       <= 4'h0;
            o_seq_busy         <= 1'b0;
        end else begin
            o_pll_en           <= next_pll_en;
            o_rx_path_en       <= next_rx_path_en;
            o_baseband_en      <= next_baseband_en;
            o_agc_override     <= next_agc_override;
            o_offset_loop_en   <= next_loop_en;
            o_offset_speed     <= next_speed;
            o_offset_threshold <= dc_ctrl[THRESH_LSB +: 2];
            o_ref_clock_out_en <= ~shutdown[SD_REFBUF_BIT];
            o_osc_core_select  <= next_pll_en ? vco_ctrl[OSC_SEL_LSB +: 2] : 2'h0;
            o_lpf_bandwidth    <= bb_ctrl[LPF_BW_LSB +: 4];
            o_balun_tune       <= trk_filter[BALUN_LSB +: 4];
            o_seq_busy         <= (state == SEQ_PLL) | (state == SEQ_CAL);
        end
    end

endmodule : tpds_sequencer

/* test/tpds_sequencer_properties.sv */
/*
 * Concurrent checks on the sequencer's power and offset-loop outputs.
 * Assumes it is bound onto tpds_sequencer and receives its step lengths.
 */
`timescale 1ns/100ps
module tpds_sequencer_properties
    import tpds_pkg::*;
#(
    parameter int PLL_SETTLE = 20, // PLL step, cycles
    parameter int CAL_LEN    = 10  // Calibration step, cycles
) (
    input  wire logic       i_core_clk,           // Core clock
    input  wire logic       i_rst,                // Async reset
    input  wire logic       i_hw_powerdown_n,     // Power-down pin
    input  wire logic       i_autocal_select_pin, // Start-up select
    input  wire logic       o_pll_en,             // PLL power
    input  wire logic       o_rx_path_en,         // RF path power
    input  wire logic       o_baseband_en,        // Baseband power
    input  wire logic       o_agc_override,       // Gain override
    input  wire logic       o_offset_loop_en,     // Loop running
    input  wire logic [1:0] o_offset_speed,       // Applied rate
    input  wire logic       o_seq_busy            // Sequencing
);
    int agc_cnt;
    int busy_cnt;

    // Run lengths of the override and busy levels
    always_ff @(posedge i_core_clk or posedge i_rst) begin
        if (i_rst) begin
            agc_cnt  <= 0;
            busy_cnt <= 0;
        end else begin
            agc_cnt  <= o_agc_override ? agc_cnt + 1 : 0;
            busy_cnt <= o_seq_busy ? busy_cnt + 1 : 0;
        end
    end

    default clocking @(posedge i_core_clk);
    endclocking
    default disable iff (i_rst);

    pd_all_off_a: assert property (
        !i_hw_powerdown_n [*3] |-> !(o_pll_en | o_rx_path_en | o_baseband_en | o_agc_override | o_offset_loop_en))
        else $error("Block powered during hardware power-down");
    pll_first_a: assert property (
        $rose(i_hw_powerdown_n) && !$past(i_hw_powerdown_n, 2) && !i_autocal_select_pin
        |-> ##2 o_pll_en && o_seq_busy && !o_rx_path_en)
        else $error("Sequenced start did not power PLL alone");
    no_sequence_a: assert property (
        $rose(i_hw_powerdown_n) && !$past(i_hw_powerdown_n, 2) && i_autocal_select_pin
        |-> ##1 !o_seq_busy [*4])
        else $error("Sequence ran with calibration pin high");
    cal_drive_a: assert property (
        o_agc_override |-> o_pll_en && o_rx_path_en && o_baseband_en && o_offset_loop_en
        && o_offset_speed == SPEED_FAST)
        else $error("Calibration step outputs wrong");
    cal_length_a: assert property (
        $fell(o_agc_override) && i_hw_powerdown_n && $past(i_hw_powerdown_n) && $past(i_hw_powerdown_n, 2)
        |-> agc_cnt == CAL_LEN)
        else $error("Calibration step length wrong");
    hold_stops_a: assert property (
        o_offset_loop_en && !o_agc_override |-> o_offset_speed != SPEED_HOLD)
        else $error("Loop running at hold speed");
    busy_pll_a: assert property (
        o_seq_busy |-> o_pll_en)
        else $error("Sequencing without PLL power");
    seq_bound_a: assert property (
        o_seq_busy |-> busy_cnt <= PLL_SETTLE + CAL_LEN + 2)
        else $error("Start-up sequence too long");
endmodule : tpds_sequencer_properties

bind tpds_sequencer tpds_sequencer_properties #(.PLL_SETTLE(PLL_SETTLE), .CAL_LEN(CAL_LEN))
    i_tpds_sequencer_properties (.*);

/* test/tpds_host_model.sv */
/*
 * Host side of the two-wire bus: start, stop, byte and register tasks.
 * Assumes a pull-up on the data line and a slave sampling on the core clock.
 */
`timescale 1ns/100ps
module tpds_host_model
    import tpds_pkg::*;
(
    input  wire logic i_core_clk, // Core clock
    input  wire logic i_sda_oe,   // Device pulls data low
    output logic      o_scl,      // Serial clock
    output wire logic o_sda       // Resolved data line
);
    logic pull_low;
    int   acks;

    assign o_sda = ~(pull_low | i_sda_oe);

    initial begin
        o_scl    = 1'b1;
        pull_low = 1'b0;
        acks     = 0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_core_clk);
    endtask : tick

    // Also serves as repeated start
    task automatic start_cond();
        o_scl = 1'b0;
        tick(1);
        pull_low = 1'b0;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        pull_low = 1'b1;
        tick(2);
    endtask : start_cond

    task automatic stop_cond();
        o_scl = 1'b0;
        tick(1);
        pull_low = 1'b1;
        tick(2);
        o_scl = 1'b1;
        tick(2);
        pull_low = 1'b0;
        tick(2);
    endtask : stop_cond

    task automatic bit_cycle(input logic b, output logic seen);
        o_scl = 1'b0;
        tick(1);
        pull_low = ~b;
        tick(2);
        o_scl = 1'b1;
        tick(1);
        seen = o_sda;
        tick(1);
    endtask : bit_cycle

    task automatic send_byte(input logic [7:0] v);
        logic s;
        for (int i = 7; i >= 0; i--) bit_cycle(v[i], s);
        bit_cycle(1'b1, s);
        if (s === 1'b0) acks++;
    endtask : send_byte

    task automatic write_reg(input logic [7:0] a, input logic [7:0] d, input logic [6:0] dev = DEV_ADDR);
        start_cond();
        send_byte({dev, 1'b0});
        send_byte(a);
        send_byte(d);
        stop_cond();
    endtask : write_reg

    // Ends the read with a master nack
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        logic s;
        start_cond();
        send_byte({DEV_ADDR, 1'b0});
        send_byte(a);
        start_cond();
        send_byte({DEV_ADDR, 1'b1});
        for (int i = 7; i >= 0; i--) bit_cycle(1'b1, d[i]);
        bit_cycle(1'b1, s);
        stop_cond();
    endtask : read_reg
endmodule : tpds_host_model

/* test/tpds_sequencer_tb.sv */
/*
 * Self-checking bench for the power-up sequencer, driven through the host model.
 * Assumes shortened step lengths and inputs changed at the falling clock edge.
 */
`timescale 1ns/100ps
module tpds_sequencer_tb;
    import tpds_pkg::*;
    localparam int PLL_T = 20;
    localparam int CAL_T = 10;
    logic       i_core_clk, i_rst, i_hw_powerdown_n, i_autocal_select_pin, i_scl, i_sda, o_sda_out, o_sda_oe;
    logic       o_pll_en, o_rx_path_en, o_baseband_en, o_ref_clock_out_en, o_agc_override, o_offset_loop_en;
    logic       o_seq_busy;
    logic [1:0] o_offset_speed, o_offset_threshold, o_osc_core_select;
    logic [3:0] o_lpf_bandwidth, o_balun_tune;
    logic [7:0] rd;
    int         n_errors, compares, n, acks0;
    logic [7:0] r_addr [5] = '{ADDR_TRK_FILTER, ADDR_SHUTDOWN, ADDR_BB_CTRL, ADDR_VCO_CTRL, ADDR_DC_CTRL};
    logic [7:0] r_val  [5] = '{RST_TRK_FILTER, RST_SHUTDOWN, RST_BB_CTRL, RST_VCO_CTRL, RST_DC_CTRL};

    tpds_sequencer #(.PLL_SETTLE(PLL_T), .CAL_LEN(CAL_T)) i_tpds_sequencer (.*);
    tpds_host_model i_tpds_host_model (.i_core_clk(i_core_clk), .i_sda_oe(o_sda_oe), .o_scl(i_scl), .o_sda(i_sda));

    initial begin
        i_core_clk = 1'b0;
        forever #10 i_core_clk = ~i_core_clk;
    end

    task automatic give_verdict();
        $display("compares %0d n_errors %0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic wait_lvl(ref logic sig, input logic lvl, output int cyc);
        cyc = 0;
        while (sig !== lvl) begin
            @(negedge i_core_clk);
            cyc++;
            if (cyc > 200) begin
                n_errors++;
                give_verdict();
            end
        end
    endtask : wait_lvl

    initial begin
        n_errors = 0;
        compares = 0;
        i_rst = 1'b1;
        i_hw_powerdown_n = 1'b0;
        i_autocal_select_pin = 1'b0;
        repeat (4) @(negedge i_core_clk);
        i_rst = 1'b0;
        i_tpds_host_model.tick(2);
        for (int i = 0; i < 5; i++) begin
            i_tpds_host_model.read_reg(r_addr[i], rd);
            check("reset value", rd, r_val[i]);
        end
        check("ref buffer in power-down", o_ref_clock_out_en, 1'b1);
        check("data out level", o_sda_out, 1'b0);
        check("power-down outputs", {o_pll_en, o_rx_path_en, o_baseband_en, o_offset_loop_en}, 4'h0);
        i_tpds_host_model.write_reg(ADDR_SHUTDOWN, 8'h80);
        check("ref buffer off", o_ref_clock_out_en, 1'b0);
        i_tpds_host_model.write_reg(ADDR_SHUTDOWN, 8'h00);
        check("ref buffer on", o_ref_clock_out_en, 1'b1);
        // Host setup: filter entry 9 with cutoff offset -1, balun 2..14 at 620 MHz
        i_tpds_host_model.write_reg(ADDR_BB_CTRL, 8'((9 - 1) << LPF_BW_LSB));
        i_tpds_host_model.write_reg(ADDR_TRK_FILTER, 8'(((2 * 310 + 12 * 150 + 155) / 310) << BALUN_LSB));
        i_tpds_host_model.write_reg(ADDR_DC_CTRL, 8'h18);
        i_hw_powerdown_n = 1'b1;
        wait_lvl(o_seq_busy, 1'b1, n);
        check("PLL step powers", {o_pll_en, o_rx_path_en, o_baseband_en, o_agc_override}, 4'h8);
        wait_lvl(o_agc_override, 1'b1, n);
        check("PLL step length", 8'(n), 8'(PLL_T));
        check("cal step", {o_rx_path_en, o_baseband_en, o_offset_loop_en, o_offset_speed}, 5'h1F);
        wait_lvl(o_agc_override, 1'b0, n);
        check("cal length", 8'(n), 8'(CAL_T));
        wait_lvl(o_seq_busy, 1'b0, n);
        check("finish delay", 8'(n <= 3), 8'h01);
        check("single cancel", {o_offset_loop_en, o_offset_speed}, 3'h0);
        check("run state", {o_osc_core_select, o_offset_threshold, o_lpf_bandwidth, o_balun_tune}, 12'h688);
        i_hw_powerdown_n = 1'b0;
        i_tpds_host_model.tick(3);
        check("off again", {o_pll_en, o_rx_path_en, o_baseband_en, o_agc_override}, 4'h0);
        i_tpds_host_model.read_reg(ADDR_BB_CTRL, rd);
        check("kept filter", rd, 8'h80);
        i_autocal_select_pin = 1'b1;
        i_hw_powerdown_n = 1'b1;
        i_tpds_host_model.tick(4);
        check("no sequence", {o_seq_busy, o_agc_override, o_offset_loop_en, o_rx_path_en}, 4'h1);
        i_autocal_select_pin = 1'b0;
        for (int k = 0; k < 4; k++) begin
            i_tpds_host_model.write_reg(ADDR_DC_CTRL, 8'(8'h10 | (k << THRESH_LSB) | k));
            check("speed", o_offset_speed, 8'(k));
            check("threshold", o_offset_threshold, 8'(k));
            check("loop", {o_offset_loop_en, o_seq_busy}, {k != 0, 1'b0});
        end
        acks0 = i_tpds_host_model.acks;
        i_tpds_host_model.write_reg(ADDR_BB_CTRL, 8'h30, 7'h61);
        check("foreign address acks", 8'(i_tpds_host_model.acks - acks0), 8'h00);
        i_tpds_host_model.write_reg(8'h20, 8'h5A);
        i_tpds_host_model.read_reg(8'h20, rd);
        check("unmapped read", rd, 8'h00);
        check("filter untouched", o_lpf_bandwidth, 4'h8);
        i_tpds_host_model.write_reg(ADDR_SHUTDOWN, 8'hFF);
        i_tpds_host_model.write_reg(ADDR_VCO_CTRL, 8'h00);
        i_tpds_host_model.write_reg(ADDR_DC_CTRL, 8'h00);
        check("soft shutdown", {o_pll_en, o_rx_path_en, o_baseband_en, o_ref_clock_out_en, o_offset_loop_en,
            o_osc_core_select}, 7'h00);
        give_verdict();
    end
endmodule : tpds_sequencer_tb
